// ===== logic/astc_defines.vh
`ifndef ASTC_DEFINES_VH
`define ASTC_DEFINES_VH

// ---------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------
// the step register sits at word index 9e; its byte address is four
// times the index so every register stays one aligned word
`define ASTC_STEP_CFG_INDEX 10'h09e
`define ASTC_STEP_CFG_ADDR 12'h278
`define ASTC_SEQ_CTRL_ADDR 12'h004
`define ASTC_SEQ_STAT_ADDR 12'h008

// ---------------------------------------------------------------------
// step configuration fields
// ---------------------------------------------------------------------
`define ASTC_EN_BIT 15
`define ASTC_GAIN_HI 14
`define ASTC_GAIN_LO 13
`define ASTC_RSVD_HI 12
`define ASTC_RSVD_LO 5
`define ASTC_NEG_BIT 4
`define ASTC_POS_HI 3
`define ASTC_POS_LO 0
`define ASTC_INT_SRC_BIT 3

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define ASTC_RST_EN 1'b0
`define ASTC_RST_GAIN 2'h0
`define ASTC_RST_NEG 1'b0
`define ASTC_RST_POS 4'he

// ---------------------------------------------------------------------
// gain and input encodings
// ---------------------------------------------------------------------
`define ASTC_GAIN_X1 3'h1
`define ASTC_GAIN_X2 3'h2
`define ASTC_GAIN_X4 3'h4
`define ASTC_NEG_GND 2'h0
`define ASTC_NEG_IN7 2'h1
`define ASTC_NEG_AUTO 2'h2

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define ASTC_CONV_CYCLES 8'h10

`endif

// ===== logic/astc_step_config.v
// Our own choices: the address map and the APB slave port.
`include "astc_defines.vh"

module astc_step_config #(
    parameter CONV_CYCLES = 8
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_step_reached,
    output reg o_step_skip,
    output reg o_conv_active,
    output reg o_conv_done,
    output reg [2:0] o_conv_gain,
    output reg [3:0] o_conv_positive,
    output reg [1:0] o_conv_negative
);
    // -----------------------------------------------------------------
    // state and storage
    // -----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg step_fourteen_enable_reg;
    reg [1:0] step_fourteen_gain_select_reg;
    reg step_fourteen_negative_input_reg;
    reg [3:0] step_fourteen_positive_input_reg;
    reg state_reg;
    reg [7:0] count_reg;
    reg [15:0] conversions_reg;
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    reg addr_ok;
    wire [2:0] dec_gain;
    wire [1:0] dec_neg;
    wire dec_internal;
    wire wr_en;
    wire rd_en;
    wire [15:0] step_word;

    // -----------------------------------------------------------------
    // apb slave
    // -----------------------------------------------------------------
    // zero wait states keeps the answer one cycle after setup
    assign wr_en = i_psel & i_penable & i_pwrite;
    assign rd_en = i_psel & ~i_penable & ~i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign o_prdata = prdata_reg;

    // reserved bits are hard zero, so they can never be written
    assign step_word = {step_fourteen_enable_reg,
                        step_fourteen_gain_select_reg,
                        8'h00,
                        step_fourteen_negative_input_reg,
                        step_fourteen_positive_input_reg};

    // address decode
    always @* begin
        addr_ok = 1'b1;
        prdata_next = 32'h0000_0000;
        if (i_paddr == `ASTC_STEP_CFG_ADDR) begin
            prdata_next = {16'h0000, step_word};
        end else if (i_paddr == `ASTC_SEQ_STAT_ADDR) begin
            prdata_next = {conversions_reg, 15'h0000, state_reg};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // read data captured in setup, presented during access
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_reg <= prdata_next;
        end
    end

    // -----------------------------------------------------------------
    // step configuration register
    // -----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            step_fourteen_enable_reg <= `ASTC_RST_EN;
            step_fourteen_gain_select_reg <= `ASTC_RST_GAIN;
            step_fourteen_negative_input_reg <= `ASTC_RST_NEG;
            step_fourteen_positive_input_reg <= `ASTC_RST_POS;
        end else if (wr_en && i_paddr == `ASTC_STEP_CFG_ADDR) begin
            step_fourteen_enable_reg <= i_pwdata[`ASTC_EN_BIT];
            step_fourteen_gain_select_reg <=
                i_pwdata[`ASTC_GAIN_HI:`ASTC_GAIN_LO];
            step_fourteen_negative_input_reg <= i_pwdata[`ASTC_NEG_BIT];
            step_fourteen_positive_input_reg <=
                i_pwdata[`ASTC_POS_HI:`ASTC_POS_LO];
        end
    end

    astc_step_decode u_decode (
        .i_gain_select(step_fourteen_gain_select_reg),
        .i_negative_input(step_fourteen_negative_input_reg),
        .i_positive_input(step_fourteen_positive_input_reg),
        .o_gain(dec_gain),
        .o_neg_sel(dec_neg),
        .o_internal(dec_internal)
    );

    // -----------------------------------------------------------------
    // step execution
    // -----------------------------------------------------------------
    // settings latch at step entry so a write mid-conversion cannot
    // disturb the running conversion
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            conversions_reg <= 16'h0000;
            o_step_skip <= 1'b0;
            o_conv_active <= 1'b0;
            o_conv_done <= 1'b0;
            o_conv_gain <= `ASTC_GAIN_X1;
            o_conv_positive <= `ASTC_RST_POS;
            o_conv_negative <= `ASTC_NEG_GND;
        end else begin
            o_step_skip <= 1'b0;
            o_conv_done <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (i_step_reached) begin
                        if (step_fourteen_enable_reg) begin
                            state_reg <= ST_CONV;
                            count_reg <= CONV_CYCLES[7:0];
                            o_conv_active <= 1'b1;
                            o_conv_gain <= dec_gain;
                            o_conv_positive <=
                                step_fourteen_positive_input_reg;
                            o_conv_negative <= dec_neg;
                        end else begin
                            o_step_skip <= 1'b1;
                        end
                    end
                end
                ST_CONV: begin
                    if (count_reg == 8'h01) begin
                        state_reg <= ST_IDLE;
                        o_conv_active <= 1'b0;
                        o_conv_done <= 1'b1;
                        conversions_reg <= conversions_reg + 16'h0001;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // astc_step_config

// ===== logic/astc_step_decode.v
`include "astc_defines.vh"

// ---------------------------------------------------------------------
// decodes stored step fields into converter settings
// ---------------------------------------------------------------------
module astc_step_decode (
    input wire [1:0] i_gain_select,
    input wire i_negative_input,
    input wire [3:0] i_positive_input,
    output reg [2:0] o_gain,
    output reg [1:0] o_neg_sel,
    output reg o_internal
);
    // gain codes 10 and 11 both give x4
    always @* begin
        case (i_gain_select)
            2'h0: o_gain = `ASTC_GAIN_X1;
            2'h1: o_gain = `ASTC_GAIN_X2;
            default: o_gain = `ASTC_GAIN_X4;
        endcase
    end

    // internal sources pick their own negative input, bit 4 ignored
    always @* begin
        o_internal = i_positive_input[`ASTC_INT_SRC_BIT];
        if (o_internal) begin
            o_neg_sel = `ASTC_NEG_AUTO;
        end else if (i_negative_input) begin
            o_neg_sel = `ASTC_NEG_IN7;
        end else begin
            o_neg_sel = `ASTC_NEG_GND;
        end
    end
endmodule // astc_step_decode

// ===== tb/astc_step_config_checker.sv
module astc_step_config_checker #(
    parameter CONV_CYCLES = 8
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_step_reached,
    input wire o_step_skip,
    input wire o_conv_active,
    input wire o_conv_done,
    input wire [2:0] o_conv_gain,
    input wire [3:0] o_conv_positive,
    input wire [1:0] o_conv_negative
);
    // ----------------------------------------
    // shadow register and run-length counter
    // ----------------------------------------
    reg [15:0] sh_reg;
    reg [7:0] cnt_reg;
    wire acc = i_psel && i_penable;
    // steps near pulses are left out: idle there is not pinned down
    wire st = i_step_reached && !o_conv_active && !o_conv_done
        && !o_step_skip;
    wire on = st && sh_reg[15];
    wire [2:0] g_exp = sh_reg[14] ? 3'h4 : (sh_reg[13] ? 3'h2 : 3'h1);
    wire [1:0] n_exp = sh_reg[3] ? 2'h2 : {1'b0, sh_reg[4]};
    // shadow follows writes so no design internals are needed
    always @(posedge i_clock) begin
        if (!i_rst_n)
            sh_reg <= 16'h000e;
        else if (acc && i_pwrite && i_paddr == 12'h278)
            sh_reg <= i_pwdata[15:0];
        cnt_reg <= o_conv_active ? cnt_reg + 8'h01 : 8'h00;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rsvd;
        acc && !i_pwrite && i_paddr == 12'h278 |->
            o_prdata[31:16] == 16'h0000 && o_prdata[12:5] == 8'h00;
    endproperty
    property p_skip;
        st && !sh_reg[15] |=> o_step_skip && !o_conv_active;
    endproperty
    property p_start;
        on |=> o_conv_active && !o_step_skip;
    endproperty
    property p_gain;
        on |=> o_conv_gain == $past(g_exp);
    endproperty
    property p_neg;
        on |=> o_conv_negative == $past(n_exp);
    endproperty
    property p_pos;
        on |=> o_conv_positive == $past(sh_reg[3:0]);
    endproperty
    property p_rst;
        !$past(i_rst_n) |-> o_conv_gain == 3'h1
            && o_conv_positive == 4'he && !o_conv_active;
    endproperty
    property p_len;
        $fell(o_conv_active) |-> cnt_reg == CONV_CYCLES && o_conv_done;
    endproperty
    property p_hold;
        o_conv_active && $past(o_conv_active) |->
            $stable(o_conv_gain) && $stable(o_conv_positive);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_skip: assert property (p_skip) else $error("no skip");
    a_start: assert property (p_start) else $error("no start");
    a_gain: assert property (p_gain) else $error("bad gain");
    a_neg: assert property (p_neg) else $error("bad negative");
    a_pos: assert property (p_pos) else $error("bad positive");
    a_rst: assert property (p_rst) else $error("bad reset");
    a_len: assert property (p_len) else $error("bad length");
    a_hold: assert property (p_hold) else $error("setting moved");
    c_on: cover property (on);
    c_skip: cover property (st && !sh_reg[15]);
    c_done: cover property (o_conv_done);
endmodule // astc_step_config_checker

bind astc_step_config astc_step_config_checker #(
    .CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// ===== tb/tb.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and design
    // ----------------------------------------
    reg i_clock = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    reg i_step_reached = 0;
    reg [11:0] i_paddr = 0;
    reg [31:0] i_pwdata = 0;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_step_skip, o_conv_active, o_conv_done;
    wire [2:0] o_conv_gain;
    wire [3:0] o_conv_positive;
    wire [1:0] o_conv_negative;
    int fail_count = 0, checked = 0, i;
    astc_step_config #(.CONV_CYCLES(4)) DUT (.*);
    always #10 i_clock = ~i_clock;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    // apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] e, input logic err);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        `CHK(o_pslverr, err)
        if (!w) `CHK(o_prdata, e)
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    // program the step, reach it, check what the converter got
    task step(input logic [15:0] c, input logic [2:0] g, input logic [1:0] n);
        apb(1, 12'h278, {16'h0, c}, 0, 0);
        i_step_reached <= 1'b1;
        @(posedge i_clock);
        i_step_reached <= 1'b0;
        #1;
        `CHK(o_conv_active, c[15])
        `CHK(o_step_skip, ~c[15])
        if (c[15]) begin
            `CHK(o_conv_gain, g)
            `CHK(o_conv_positive, c[3:0])
            `CHK(o_conv_negative, n)
            repeat (20) begin
                @(posedge i_clock);
                #1;
                if (o_conv_done === 1'b1) break;
            end
            `CHK(o_conv_done, 1'b1)
        end
        @(posedge i_clock);
    endtask
    task final_report;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        apb(0, 12'h278, 0, 32'h0000000e, 0);
        apb(1, 12'h278, 32'hffffffff, 0, 0);
        apb(0, 12'h278, 0, 32'h0000e01f, 0);
        apb(0, 12'h010, 0, 0, 1);
        // every positive code, gain code and negative bit in turn
        for (i = 0; i < 16; i++)
            step({1'b1, i[1:0], 8'h00, i[2], i[3:0]},
                 i[1] ? 3'h4 : (i[0] ? 3'h2 : 3'h1),
                 i[3] ? 2'h2 : {1'b0, i[2]});
        step(16'h0003, 3'h1, 2'h0);
        // sixteen enabled steps ran, the skipped one is not counted
        apb(0, 12'h008, 0, 32'h0010_0000, 0);
        final_report;
    end
    // the run takes under two hundred cycles; this bound only cuts a hang
    initial begin
        #50000;
        fail_count++;
        final_report;
    end
endmodule // tb
